// ==== rtl/run_sync_pkg.sv ====
// Package: register map, field layout, timing constants and carrier types for run/sync control
package run_sync_pkg;

  // Clock and timing
  localparam int unsigned CORE_CLK_MHZ      = 25;
  localparam int unsigned CORE_PERIOD_NS    = 1000 / CORE_CLK_MHZ;
  localparam int unsigned TAG_RATE_MHZ      = 125;
  localparam int unsigned TAG_STEP          = TAG_RATE_MHZ / CORE_CLK_MHZ;
  localparam int unsigned SYNC_PULSE_NS     = 160;
  localparam int unsigned SYNC_PULSE_CYC    =
    (SYNC_PULSE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned TRG_LATENCY_CYC   = 4;

  // Sample path shape
  localparam int unsigned CHANNELS          = 4;
  localparam int unsigned SAMPLE_W          = 12;

  // Register byte offsets
  localparam logic [7:0] ACQ_CTRL_OFS       = 8'h00;
  localparam logic [7:0] ACQ_STATUS_OFS     = 8'h04;
  localparam logic [7:0] TAG_CAPTURE_OFS    = 8'h08;
  localparam logic [7:0] TAG_NOW_OFS        = 8'h0c;
  localparam logic [7:0] CLK_CFG_OFS        = 8'h10;

  // Control register fields
  localparam int unsigned CTRL_MODE_LSB     = 0;
  localparam int unsigned CTRL_RUN_BIT      = 2;
  localparam int unsigned CTRL_GATE_BIT     = 3;
  localparam int unsigned CTRL_R1SYNC_BIT   = 4;
  localparam int unsigned CTRL_REV2_BIT     = 5;

  // Status register fields
  localparam int unsigned STAT_RUNNING_BIT  = 0;
  localparam int unsigned STAT_GATE_BIT     = 1;
  localparam int unsigned STAT_SYNC_BIT     = 2;

  // Reset values
  localparam logic [1:0]  MODE_RESET        = 2'h0;
  localparam logic        REV2_RESET        = 1'b0;
  localparam logic [31:0] CLK_CFG_RESET     = 32'h0000_0000;

  // Run modes
  typedef enum logic [1:0] {
    MODE_REG   = 2'b00,
    MODE_INPUT = 2'b01,
    MODE_RSV2  = 2'b10,
    MODE_RSV3  = 2'b11
  } run_mode_t;

  // Avalon-MM slave request and answer
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } avmm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } avmm_rsp_t;

  typedef logic [CHANNELS*SAMPLE_W-1:0] sample_vec_t;

endpackage

// ==== rtl/digitizer_run_sync_gate.sv ====
// Acquisition run control, gating, trigger relay, time tag and divider sync strobe
// Behaviour
// - Sync strobe edge realigns every sampling divider
// - Board reset issues sync strobe automatically
// - Later boards launch strobe on reference clock edge
// - First-revision: sync-start rising edge pulses strobe
// - Unaligned trigger may shift window one sample
// - Trigger output follows input after fixed latency
// - Run bit set starts acquisition in both modes
// - Mode 01: sync-start high starts acquisition
// - Run bit cleared stops acquisition in both modes
// - Mode 01: sync-start low stops acquisition
// - Gate mode stores samples only while input high
// - One sample per channel each sampling tick
// - Trigger while running captures 32-bit time tag
// - Clock configuration reloadable without power cycle
// - Trigger logic runs at half sampling rate
// - Time tag advances at fixed 125 MHz rate
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
module digitizer_run_sync_gate
  import run_sync_pkg::*;
(
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  // Avalon-MM register slave
  input  wire run_sync_pkg::avmm_req_t  avmm_req,
  output      run_sync_pkg::avmm_rsp_t  avmm_rsp,
  // Front panel and reference
  input  wire logic                     external_ref_clock,
  input  wire logic                     sync_start,
  input  wire logic                     trigger_input,
  output      logic                     trigger_output,
  // Clock chip control
  output      logic                     divider_sync_n,
  output      logic [31:0]              clk_cfg_word,
  output      logic                     clk_cfg_load,
  // Sample path
  input  wire logic                     sample_tick,
  input  wire run_sync_pkg::sample_vec_t sample_in,
  output      logic                     sample_store,
  output      run_sync_pkg::sample_vec_t sample_out
);
  import run_sync_pkg::*;

  typedef struct packed {
    logic                        ack;
    logic [31:0]                 rdata;
    logic [1:0]                  mode;
    logic                        run;
    logic                        gate_en;
    logic                        r1sync_en;
    logic                        rev2;
    logic                        running;
    logic                        start_s1;
    logic                        start_s2;
    logic                        start_d;
    logic                        trg_s1;
    logic                        trg_s2;
    logic                        trg_d;
    logic                        ref_s1;
    logic                        ref_s2;
    logic                        ref_d;
    logic                        phase;
    logic [31:0]                 tag_now;
    logic [31:0]                 tag_cap;
    logic [TRG_LATENCY_CYC-1:0]  trg_pipe;
    logic                        sync_pend;
    logic [3:0]                  sync_cnt;
    logic                        sync_n;
    logic [31:0]                 cfg_word;
    logic                        cfg_load;
    logic                        store;
    sample_vec_t                 sdata;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic       wr_hit;
  logic       start_rise;
  logic       start_fall;
  logic       trg_seen;
  logic       ref_rise;
  logic       launch;
  logic [7:0] addr;

  // Combinational decode of events shared by the next-state logic and the checks
  always_comb
  begin
    addr       = avmm_req.address;
    wr_hit     = st_reg.ack && avmm_req.write;
    start_rise = st_reg.start_s2 && !st_reg.start_d;
    start_fall = !st_reg.start_s2 && st_reg.start_d;
    ref_rise   = st_reg.ref_s2 && !st_reg.ref_d;
    trg_seen   = st_reg.trg_s2 && !st_reg.trg_d && st_reg.phase;
    launch     = st_reg.sync_pend && (st_reg.sync_cnt == 4'h0)
                 && (!st_reg.rev2 || ref_rise);
  end

  // Next state; one process so every field has a single driver
  always_comb
  begin
    st_next = st_reg;

    // Bus handshake: one wait cycle, answer stands for one cycle
    st_next.ack = (avmm_req.read || avmm_req.write) && !st_reg.ack;
    if (avmm_req.read && !st_reg.ack)
    begin
      unique case (addr)
        ACQ_CTRL_OFS:
          st_next.rdata = {26'h0, st_reg.rev2, st_reg.r1sync_en, st_reg.gate_en,
                           st_reg.run, st_reg.mode};
        ACQ_STATUS_OFS:
          st_next.rdata = {29'h0, !st_reg.sync_n, st_reg.start_s2, st_reg.running};
        TAG_CAPTURE_OFS:
          st_next.rdata = st_reg.tag_cap;
        TAG_NOW_OFS:
          st_next.rdata = st_reg.tag_now;
        CLK_CFG_OFS:
          st_next.rdata = st_reg.cfg_word;
        default:
          st_next.rdata = 32'h0000_0000;
      endcase
    end

    // Control register write commits on the answering edge
    st_next.cfg_load = 1'b0;
    if (wr_hit && addr == ACQ_CTRL_OFS)
    begin
      st_next.mode      = avmm_req.writedata[CTRL_MODE_LSB +: 2];
      st_next.run       = avmm_req.writedata[CTRL_RUN_BIT];
      st_next.gate_en   = avmm_req.writedata[CTRL_GATE_BIT];
      st_next.r1sync_en = avmm_req.writedata[CTRL_R1SYNC_BIT];
      st_next.rev2      = avmm_req.writedata[CTRL_REV2_BIT];
    end
    if (wr_hit && addr == CLK_CFG_OFS)
    begin
      st_next.cfg_word = avmm_req.writedata;
      st_next.cfg_load = 1'b1;
    end

    // two-stage synchronisers; first stage feeds only the second
    st_next.start_s1 = sync_start;
    st_next.start_s2 = st_reg.start_s1;
    st_next.start_d  = st_reg.start_s2;
    st_next.trg_s1   = trigger_input;
    st_next.trg_s2   = st_reg.trg_s1;
    st_next.ref_s1   = external_ref_clock;
    st_next.ref_s2   = st_reg.ref_s1;
    st_next.ref_d    = st_reg.ref_s2;
    // Trigger edge memory only advances on trigger-logic phase
    if (st_reg.phase)
      st_next.trg_d = st_reg.trg_s2;
    st_next.phase = !st_reg.phase;

    // Run control; reserved modes keep acquisition stopped
    if (wr_hit && addr == ACQ_CTRL_OFS &&
        run_mode_t'(avmm_req.writedata[CTRL_MODE_LSB +: 2]) inside {MODE_REG, MODE_INPUT})
    begin
      st_next.running = avmm_req.writedata[CTRL_RUN_BIT];
    end
    else if (run_mode_t'(st_reg.mode) == MODE_INPUT && start_rise)
      st_next.running = 1'b1;
    else if (run_mode_t'(st_reg.mode) == MODE_INPUT && start_fall)
      st_next.running = 1'b0;
    else if (!(run_mode_t'(st_reg.mode) inside {MODE_REG, MODE_INPUT}))
      st_next.running = 1'b0;

    // tag steps five per core cycle, restarted as acquisition starts
    if (st_next.running && !st_reg.running)
      st_next.tag_now = 32'h0000_0000;
    else
      st_next.tag_now = st_reg.tag_now + 32'(TAG_STEP);

    // time tag capture; asynchronous trigger may land one phase late
    if (trg_seen && st_reg.running)
      st_next.tag_cap = st_reg.tag_now;

    // fixed-latency relay toward the next board
    st_next.trg_pipe = {st_reg.trg_pipe[TRG_LATENCY_CYC-2:0], trg_seen};

    // gate mode stores only while input high
    // one word per channel per tick
    st_next.store = sample_tick && st_reg.running && (!st_reg.gate_en || st_reg.start_s2);
    if (sample_tick)
      st_next.sdata = sample_in;

    // first-revision start edge request; set wins over launch
    st_next.sync_pend = (st_reg.sync_pend && !launch)
                        || (start_rise && st_reg.r1sync_en && !st_reg.rev2)
                        || (wr_hit && addr == CLK_CFG_OFS);
    // strobe low for a fixed span realigns dividers
    if (launch)
      st_next.sync_cnt = 4'(SYNC_PULSE_CYC);
    else if (st_reg.sync_cnt != 4'h0)
      st_next.sync_cnt = st_reg.sync_cnt - 4'h1;
    st_next.sync_n = !(launch || st_reg.sync_cnt > 4'h1);
  end

  // State register; reset leaves a pending strobe
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg           <= '0;
      st_reg.mode      <= MODE_RESET;
      st_reg.rev2      <= REV2_RESET;
      st_reg.cfg_word  <= CLK_CFG_RESET;
      st_reg.sync_n    <= 1'b1;
      st_reg.sync_pend <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // Outputs straight from state flip-flops
  assign avmm_rsp.readdata    = st_reg.rdata;
  assign avmm_rsp.waitrequest = !st_reg.ack;
  assign trigger_output       = st_reg.trg_pipe[TRG_LATENCY_CYC-1];
  assign divider_sync_n       = st_reg.sync_n;
  assign clk_cfg_word         = st_reg.cfg_word;
  assign clk_cfg_load         = st_reg.cfg_load;
  assign sample_store         = st_reg.store;
  assign sample_out           = st_reg.sdata;

  // Checks
  property p_sync_low_span;
    @(posedge core_clk) disable iff (!rst_n)
    $fell(divider_sync_n) |-> !divider_sync_n [*4] ##1 divider_sync_n;
  endproperty
  a_sync_low_span: assert property (p_sync_low_span)
    else $error("sync strobe width wrong");

  property p_reset_sync;
    @(posedge core_clk) $rose(rst_n) && !REV2_RESET |-> ##[0:2] !divider_sync_n;
  endproperty
  a_reset_sync: assert property (p_reset_sync)
    else $error("no sync strobe after reset");

  // Check the pin itself, so a broken launch term is caught too
  property p_rev2_ref;
    @(posedge core_clk) disable iff (!rst_n)
    $fell(divider_sync_n) && $past(st_reg.rev2) |-> $past(st_reg.ref_s2 && !st_reg.ref_d);
  endproperty
  a_rev2_ref: assert property (p_rev2_ref)
    else $error("rev2 strobe not on ref edge");

  property p_rev1_start;
    @(posedge core_clk) disable iff (!rst_n)
    start_rise && st_reg.r1sync_en && !st_reg.rev2 && st_reg.sync_cnt == 4'h0
    |-> ##2 !divider_sync_n;
  endproperty
  a_rev1_start: assert property (p_rev1_start)
    else $error("start edge gave no strobe");

  property p_trg_latency;
    @(posedge core_clk) disable iff (!rst_n)
    trg_seen |-> ##4 trigger_output;
  endproperty
  a_trg_latency: assert property (p_trg_latency)
    else $error("trigger output latency wrong");

  property p_input_run;
    @(posedge core_clk) disable iff (!rst_n)
    run_mode_t'(st_reg.mode) == MODE_INPUT && start_rise && !wr_hit |=> st_reg.running;
  endproperty
  a_input_run: assert property (p_input_run)
    else $error("input high did not start");

  property p_input_stop;
    @(posedge core_clk) disable iff (!rst_n)
    run_mode_t'(st_reg.mode) == MODE_INPUT && start_fall && !wr_hit |=> !st_reg.running;
  endproperty
  a_input_stop: assert property (p_input_stop)
    else $error("input low did not stop");

  property p_gate;
    @(posedge core_clk) disable iff (!rst_n)
    sample_store |-> $past(st_reg.running) && (!$past(st_reg.gate_en) || $past(st_reg.start_s2));
  endproperty
  a_gate: assert property (p_gate)
    else $error("sample stored outside gate");

  property p_tag_cap;
    @(posedge core_clk) disable iff (!rst_n)
    trg_seen && st_reg.running |=> st_reg.tag_cap == $past(st_reg.tag_now);
  endproperty
  a_tag_cap: assert property (p_tag_cap)
    else $error("time tag not captured");

  property p_tag_step;
    @(posedge core_clk) disable iff (!rst_n)
    st_reg.running && $past(st_reg.running) |-> st_reg.tag_now == $past(st_reg.tag_now) + 32'h5;
  endproperty
  a_tag_step: assert property (p_tag_step)
    else $error("time tag step wrong");

endmodule

// ==== testbench/run_sync_far_end.sv ====
// Far-side model: free-running reference clock and reference-aligned front panel drivers
`timescale 1ns/10ps
module run_sync_far_end (
  // Reference and front panel
  output logic external_ref_clock,
  output logic sync_start,
  output logic trigger_input
);
  initial
  begin
    external_ref_clock = 1'b0;
    sync_start         = 1'b0;
    trigger_input      = 1'b0;
  end
  // Reference runs free; its edges land on core falling edges, between rising edges
  always #40 external_ref_clock = ~external_ref_clock;
  task automatic set_start(input logic v);
    @(posedge external_ref_clock);
    sync_start <= v;
  endtask
  task automatic fire();
    @(posedge external_ref_clock);
    trigger_input <= 1'b1;
    @(posedge external_ref_clock);
    trigger_input <= 1'b0;
  endtask
endmodule

// ==== testbench/test_digitizer_run_sync_gate.sv ====
// Self-checking bench for run control, gating, trigger relay, time tag and sync strobe
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("[FAIL] %0t mismatch got %0h exp %0h", $time, g, e); \
    end \
  end
module test_digitizer_run_sync_gate;
  import run_sync_pkg::*;
  logic        core_clk    = 1'b0;
  logic        rst_n       = 1'b0;
  avmm_req_t   avmm_req    = '0;
  avmm_rsp_t   avmm_rsp;
  logic        external_ref_clock;
  logic        sync_start;
  logic        trigger_input;
  logic        trigger_output;
  logic        divider_sync_n;
  logic [31:0] clk_cfg_word;
  logic        clk_cfg_load;
  logic        sample_tick = 1'b0;
  sample_vec_t sample_in   = '0;
  logic        sample_store;
  sample_vec_t sample_out;
  logic [63:0] rd_q[$];
  sample_vec_t smp_q[$];
  logic [31:0] rdata;
  logic [31:0] seed        = 32'h0000_17f4;
  int          errors      = 0;
  int          comparisons = 0;
  int          loads       = 0;

  digitizer_run_sync_gate dut_u (.core_clk, .rst_n, .avmm_req, .avmm_rsp,
    .external_ref_clock, .sync_start, .trigger_input, .trigger_output, .divider_sync_n,
    .clk_cfg_word, .clk_cfg_load, .sample_tick, .sample_in, .sample_store, .sample_out);
  run_sync_far_end far_u (.external_ref_clock, .sync_start, .trigger_input);

  always #20 core_clk = ~core_clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic end_sim();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic timeout();
    errors++;
    $display("[FAIL] %0t wait ran out", $time);
    end_sim();
  endtask

  // Avalon master: request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avmm_req <= '{a, !w, w, d};
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avmm_rsp.waitrequest !== 1'b0 && n < 20);
    if (n >= 20)
      timeout();
    rdata = avmm_rsp.readdata;
    avmm_req <= '0;
  endtask

  // Read with a note of the expected bits under a mask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rd_q.push_back({e, m});
    bus(1'b0, a, 32'h0);
  endtask

  // Strobe-low cycles over a bounded stretch
  task automatic count_low(input int win, output int n);
    n = 0;
    repeat (win)
    begin
      @(posedge core_clk);
      n += int'(divider_sync_n === 1'b0);
    end
  endtask

  // Scoreboard: oldest note meets each read answer or stored sample
  always @(posedge core_clk)
  begin
    logic [63:0] note;
    if (avmm_req.read && avmm_rsp.waitrequest === 1'b0 && rd_q.size() > 0)
    begin
      note = rd_q.pop_front();
      `CHK(avmm_rsp.readdata & note[31:0], note[63:32])
    end
    if (sample_store === 1'b1)
    begin
      if (smp_q.size() == 0)
        `CHK(sample_store, 1'b0)
      else
        `CHK(sample_out, smp_q.pop_front())
    end
    // Each clock configuration write yields one load pulse
    if (clk_cfg_load === 1'b1)
      loads++;
  end

  initial
  begin
    #2000000;
    timeout();
  end

  initial
  begin
    int n;
    logic [31:0] v;
    logic [63:0] r;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    count_low(8, n);
    `CHK(n, 4)
    $display("reset strobe test done");
    // Run bit in every mode; only modes 00 and 01 honour it
    for (int m = 0; m < 4; m++)
    begin
      bus(1'b1, ACQ_CTRL_OFS, 32'h4 | m);
      rd(ACQ_STATUS_OFS, {31'h0, m < 2}, 32'h1);
      bus(1'b1, ACQ_CTRL_OFS, m);
      rd(ACQ_STATUS_OFS, 32'h0, 32'h1);
    end
    $display("run bit test done");
    // Input-controlled run follows the sync-start level
    bus(1'b1, ACQ_CTRL_OFS, 32'h1);
    far_u.set_start(1'b1);
    repeat (4) @(posedge core_clk);
    rd(ACQ_STATUS_OFS, 32'h3, 32'h3);
    far_u.set_start(1'b0);
    repeat (4) @(posedge core_clk);
    rd(ACQ_STATUS_OFS, 32'h0, 32'h3);
    bus(1'b1, ACQ_CTRL_OFS, 32'h11);
    far_u.set_start(1'b1);
    count_low(30, n);
    `CHK(n, 4)
    far_u.set_start(1'b0);
    $display("input run test done");
    // Trigger relay and time tag while running
    bus(1'b1, ACQ_CTRL_OFS, 32'h4);
    repeat (10) @(posedge core_clk);
    far_u.fire();
    n = 0;
    while (trigger_output !== 1'b1 && n < 20)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 20)
      timeout();
    `CHK(n > 2 && n < 9, 1'b1)
    @(posedge core_clk);
    `CHK(trigger_output, 1'b0)
    rd(TAG_CAPTURE_OFS, 32'h0, 32'h0);
    v = rdata;
    `CHK(v % 5, 0)
    `CHK(v != 0, 1'b1)
    rd(TAG_NOW_OFS, 32'h0, 32'h0);
    `CHK(rdata > v, 1'b1)
    $display("trigger test done");
    // Gate: low, high, low phases; only the high phase stores
    bus(1'b1, ACQ_CTRL_OFS, 32'hc);
    for (int ph = 0; ph < 3; ph++)
    begin
      far_u.set_start(ph == 1);
      repeat (4) @(posedge core_clk);
      repeat (4)
      begin
        r = {rnd(), rnd()};
        @(posedge core_clk);
        sample_tick <= 1'b1;
        sample_in <= r[47:0];
        if (ph == 1)
          smp_q.push_back(r[47:0]);
        @(posedge core_clk);
        sample_tick <= 1'b0;
      end
    end
    repeat (4) @(posedge core_clk);
    `CHK(smp_q.size(), 0)
    $display("gate test done");
    // Clock config reload with strobe, plain and reference-launched
    for (int rev = 0; rev < 2; rev++)
    begin
      bus(1'b1, ACQ_CTRL_OFS, rev << 5);
      v = rnd();
      bus(1'b1, CLK_CFG_OFS, v);
      count_low(30, n);
      `CHK(n, 4)
      `CHK(loads, rev + 1)
      `CHK(clk_cfg_word, v)
      rd(CLK_CFG_OFS, v, 32'hffff_ffff);
    end
    bus(1'b1, 8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0, 32'hffff_ffff);
    repeat (4) @(posedge core_clk);
    $display("config test done");
    // Second reset while stopped re-issues the strobe and restores control
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    count_low(8, n);
    `CHK(n, 4)
    rd(ACQ_CTRL_OFS, {26'h0, REV2_RESET, 3'h0, MODE_RESET}, 32'hffff_ffff);
    $display("second reset test done");
    end_sim();
  end
endmodule
